// File: core/tsi_flag_chan.sv
// One channel's event flag register and interrupt gate register.
// Assumes set, clear and bus strobes are one-cycle pulses on clk_sys.
`timescale 1ns/1ps
module tsi_flag_chan #(
	parameter bit HAS_DMA_CLR = 1'b1
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic standby,
	input wire logic reg_rd,
	input wire logic reg_wr,
	input wire logic reg_sel_gate,
	input wire logic [tsi_pkg::REG_W-1:0] reg_wdata,
	input wire logic set_wrap,
	input wire logic set_match_a,
	input wire logic set_match_b,
	input wire logic dma_clr_a,
	output logic [tsi_pkg::FLAG_W-1:0] flags,
	output logic [tsi_pkg::FLAG_W-1:0] gates,
	output logic wrap_irq,
	output logic match_a_irq,
	output logic match_b_irq
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [tsi_pkg::FLAG_W-1:0] flag;
		logic [tsi_pkg::FLAG_W-1:0] armed;
		logic [tsi_pkg::FLAG_W-1:0] gate;
	} tsi_chan_state_type;

	localparam tsi_chan_state_type CHAN_RST = '{
		flag: tsi_pkg::FLAGS_RST,
		armed: tsi_pkg::FLAGS_RST,
		gate: tsi_pkg::GATE_RST
	};

	tsi_chan_state_type state_ff;
	tsi_chan_state_type nxt_state;
	logic [tsi_pkg::FLAG_W-1:0] set_vec;
	logic [tsi_pkg::FLAG_W-1:0] clr_vec;
	logic flag_wr;
	logic flag_rd;

	// Event vector in register bit order
	always_comb
	begin
		set_vec = '0;
		set_vec[tsi_pkg::WRAP_BIT] = set_wrap;
		set_vec[tsi_pkg::MATCH_B_BIT] = set_match_b;
		set_vec[tsi_pkg::MATCH_A_BIT] = set_match_a;
	end

	assign flag_wr = reg_wr & ~reg_sel_gate;
	assign flag_rd = reg_rd & ~reg_sel_gate;

	// Next state: arming, clearing, setting and gate writes
	always_comb
	begin
		nxt_state = state_ff;
		// Zero written to an armed bit clears it; a one is ignored
		clr_vec = {tsi_pkg::FLAG_W{flag_wr}} & ~reg_wdata[tsi_pkg::FLAG_W-1:0] & state_ff.armed;
		if (HAS_DMA_CLR)
		begin
			clr_vec[tsi_pkg::MATCH_A_BIT] = clr_vec[tsi_pkg::MATCH_A_BIT] | dma_clr_a;
		end
		// A write consumes the arming; a read arms every bit seen at 1
		nxt_state.armed = (flag_wr ? tsi_pkg::FLAGS_RST : state_ff.armed)
			| (flag_rd ? state_ff.flag : tsi_pkg::FLAGS_RST);
		// Set wins over a clear in the same cycle
		nxt_state.flag = (state_ff.flag & ~clr_vec) | set_vec;
		if (reg_wr && reg_sel_gate)
		begin
			nxt_state.gate = reg_wdata[tsi_pkg::FLAG_W-1:0];
		end
		// Standby holds both registers at their initial values
		if (standby)
		begin
			nxt_state = CHAN_RST;
		end
	end

	// State register
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			state_ff <= CHAN_RST;
		end
		else
		begin
			state_ff <= nxt_state;
		end
	end

	// Gated requests, held while flag and enable are both 1
	assign wrap_irq = state_ff.flag[tsi_pkg::WRAP_BIT] & state_ff.gate[tsi_pkg::WRAP_BIT];
	assign match_b_irq = state_ff.flag[tsi_pkg::MATCH_B_BIT]
		& state_ff.gate[tsi_pkg::MATCH_B_BIT];
	assign match_a_irq = state_ff.flag[tsi_pkg::MATCH_A_BIT]
		& state_ff.gate[tsi_pkg::MATCH_A_BIT];
	assign flags = state_ff.flag;
	assign gates = state_ff.gate;

endmodule // tsi_flag_chan

// File: core/tsi_pkg.sv
// Constants, field layout and types shared by the timer status and interrupt gate block.
// Assumes a single 50 MHz system clock and an 8-bit byte-access register port.
package tsi_pkg;

	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int NUM_CH = 5;
	localparam int CNT_W = 16;
	localparam int REG_W = 8;
	localparam int FLAG_W = 3;
	localparam int CH_SEL_W = 3;
	localparam int DMA_CH_LAST = 3;
	localparam int PHASE_CH = 2;
	localparam int CPWM_CH_LO = 3;
	localparam int CPWM_CH_HI = 4;

	// ----------------------------------------
	// Field positions, shared by both registers
	// ----------------------------------------
	localparam int WRAP_BIT = 2;
	localparam int MATCH_B_BIT = 1;
	localparam int MATCH_A_BIT = 0;
	localparam int UNDEF_BIT = 7;
	localparam int RSVD_HI = 6;
	localparam int RSVD_LO = 3;
	localparam logic [3:0] RSVD_ONES = 4'hF;

	// ----------------------------------------
	// Reset values and counter limits
	// ----------------------------------------
	localparam logic [7:0] INIT_BIT7_HI = 8'hF8;
	localparam logic [7:0] INIT_BIT7_LO = 8'h78;
	localparam logic [FLAG_W-1:0] FLAGS_RST = 3'h0;
	localparam logic [FLAG_W-1:0] GATE_RST = 3'h0;
	localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
	localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
	localparam logic [1:0] COMBO_COMPLEMENTARY = 2'h2;

	// ----------------------------------------
	// Wide port byte lanes and register choice
	// ----------------------------------------
	localparam int LANE_HI = 1;
	localparam int LANE_LO = 0;
	typedef enum logic [2:0] {
		TSI_WIDE_CNT,
		TSI_WIDE_GRA,
		TSI_WIDE_GRB,
		TSI_WIDE_BRA,
		TSI_WIDE_BRB
	} tsi_wide_sel_type;

endpackage

// File: core/tsi_timer_status_irq.sv
// Top of the five-channel timer status flag and interrupt gate block.
// Assumes counter, compare and capture logic on clk_sys drives the event inputs,
// and that the CPU reaches the 8-bit registers by byte access only.
`timescale 1ns/1ps
module tsi_timer_status_irq #(
	parameter bit BIT7_READ = 1'b1
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic standby,
	input wire logic [tsi_pkg::CH_SEL_W-1:0] reg_sel_ch,
	input wire logic reg_sel_gate,
	input wire logic reg_rd,
	input wire logic reg_wr,
	input wire logic [tsi_pkg::REG_W-1:0] reg_wdata,
	output logic [tsi_pkg::REG_W-1:0] reg_rdata,
	output logic reg_ack,
	output logic reg_err,
	input wire logic wide_rd,
	input wire logic [tsi_pkg::CH_SEL_W-1:0] wide_sel_ch,
	input wire tsi_pkg::tsi_wide_sel_type wide_sel_reg,
	input wire logic [1:0] wide_lane,
	output logic [tsi_pkg::CNT_W-1:0] wide_rdata,
	output logic wide_ack,
	input wire logic [tsi_pkg::NUM_CH-1:0] cnt_tick,
	input wire logic [tsi_pkg::NUM_CH-1:0] cnt_down,
	input wire logic phase_count_select,
	input wire logic combo_mode_hi,
	input wire logic combo_mode_lo,
	input wire logic [tsi_pkg::NUM_CH-1:0][tsi_pkg::CNT_W-1:0] channel_counter,
	input wire logic [tsi_pkg::NUM_CH-1:0][tsi_pkg::CNT_W-1:0] general_reg_a,
	input wire logic [tsi_pkg::NUM_CH-1:0][tsi_pkg::CNT_W-1:0] general_reg_b,
	input wire logic [tsi_pkg::NUM_CH-1:0][tsi_pkg::CNT_W-1:0] buffer_reg_a,
	input wire logic [tsi_pkg::NUM_CH-1:0][tsi_pkg::CNT_W-1:0] buffer_reg_b,
	input wire logic [tsi_pkg::NUM_CH-1:0] gra_capture_mode,
	input wire logic [tsi_pkg::NUM_CH-1:0] grb_capture_mode,
	input wire logic [tsi_pkg::NUM_CH-1:0] capture_a,
	input wire logic [tsi_pkg::NUM_CH-1:0] capture_b,
	input wire logic [tsi_pkg::DMA_CH_LAST:0] dma_ack_a,
	output logic [tsi_pkg::NUM_CH-1:0] wrap_irq,
	output logic [tsi_pkg::NUM_CH-1:0] match_a_irq,
	output logic [tsi_pkg::NUM_CH-1:0] match_b_irq
);

	// ----------------------------------------
	// Bus-side state
	// ----------------------------------------
	typedef struct packed {
		logic [tsi_pkg::REG_W-1:0] rdata;
		logic ack;
		logic err;
		logic [tsi_pkg::CNT_W-1:0] wide;
		logic wide_ack;
	} tsi_top_state_type;

	localparam tsi_top_state_type TOP_RST = '{
		rdata: tsi_pkg::INIT_BIT7_HI,
		ack: 1'b0,
		err: 1'b0,
		wide: tsi_pkg::CNT_ZERO,
		wide_ack: 1'b0
	};

	tsi_top_state_type state_ff;
	tsi_top_state_type nxt_state;

	// ----------------------------------------
	// Per-channel wiring
	// ----------------------------------------
	logic [tsi_pkg::NUM_CH-1:0] ch_hit;
	logic [tsi_pkg::NUM_CH-1:0] down_ok;
	logic [tsi_pkg::NUM_CH-1:0] wrap_ev;
	logic [tsi_pkg::NUM_CH-1:0] match_a_ev;
	logic [tsi_pkg::NUM_CH-1:0] match_b_ev;
	logic [tsi_pkg::NUM_CH-1:0] dma_clr;
	logic [tsi_pkg::NUM_CH-1:0][tsi_pkg::FLAG_W-1:0] ch_flags;
	logic [tsi_pkg::NUM_CH-1:0][tsi_pkg::FLAG_W-1:0] ch_gates;
	logic complementary;
	logic sel_valid;
	logic wide_valid;
	logic [tsi_pkg::REG_W-1:0] rd_byte;
	logic [tsi_pkg::CNT_W-1:0] wide_word;

	// Complementary PWM is combo_mode_hi = 1 with combo_mode_lo = 0
	assign complementary = ({combo_mode_hi, combo_mode_lo} == tsi_pkg::COMBO_COMPLEMENTARY);

	// ----------------------------------------
	// Channel instances and event detection
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < tsi_pkg::NUM_CH; gi++)
		begin : g_ch
			// Only an up/down counting channel may wrap downward
			if (gi == tsi_pkg::PHASE_CH)
			begin : g_phase
				assign down_ok[gi] = phase_count_select;
			end
			else if (gi >= tsi_pkg::CPWM_CH_LO && gi <= tsi_pkg::CPWM_CH_HI)
			begin : g_cpwm
				assign down_ok[gi] = complementary;
			end
			else
			begin : g_up_only
				assign down_ok[gi] = 1'b0;
			end

			// Wrap upward from all-ones, or downward from zero
			assign wrap_ev[gi] = cnt_tick[gi] & (
				(~(cnt_down[gi] & down_ok[gi]) & (channel_counter[gi] == tsi_pkg::CNT_MAX))
				| (cnt_down[gi] & down_ok[gi]
				& (channel_counter[gi] == tsi_pkg::CNT_ZERO)));

			// Compare fires as the counter leaves the matching value
			assign match_a_ev[gi] = gra_capture_mode[gi] ? capture_a[gi]
				: (cnt_tick[gi] & (channel_counter[gi] == general_reg_a[gi]));
			assign match_b_ev[gi] = grb_capture_mode[gi] ? capture_b[gi]
				: (cnt_tick[gi] & (channel_counter[gi] == general_reg_b[gi]));

			// Automatic clear by DMA start exists on the lower channels only
			if (gi <= tsi_pkg::DMA_CH_LAST)
			begin : g_dma
				assign dma_clr[gi] = dma_ack_a[gi];
			end
			else
			begin : g_no_dma
				assign dma_clr[gi] = 1'b0;
			end

			// Channel select decode
			assign ch_hit[gi] = (reg_sel_ch == tsi_pkg::CH_SEL_W'(gi));

			// Independent register pair for this channel
			tsi_flag_chan #(
				.HAS_DMA_CLR(gi <= tsi_pkg::DMA_CH_LAST)
			) u_chan (
				.clk_sys(clk_sys),
				.rst(rst),
				.standby(standby),
				.reg_rd(reg_rd & ch_hit[gi]),
				.reg_wr(reg_wr & ch_hit[gi]),
				.reg_sel_gate(reg_sel_gate),
				.reg_wdata(reg_wdata),
				.set_wrap(wrap_ev[gi]),
				.set_match_a(match_a_ev[gi]),
				.set_match_b(match_b_ev[gi]),
				.dma_clr_a(dma_clr[gi]),
				.flags(ch_flags[gi]),
				.gates(ch_gates[gi]),
				.wrap_irq(wrap_irq[gi]),
				.match_a_irq(match_a_irq[gi]),
				.match_b_irq(match_b_irq[gi])
			);
		end
	endgenerate

	// ----------------------------------------
	// Byte register read path
	// ----------------------------------------
	assign sel_valid = (reg_sel_ch < tsi_pkg::CH_SEL_W'(tsi_pkg::NUM_CH));

	// Readback byte: bit 7 fixed by parameter, bits 6-3 ones, low bits live
	always_comb
	begin
		rd_byte = '0;
		rd_byte[tsi_pkg::UNDEF_BIT] = BIT7_READ;
		rd_byte[tsi_pkg::RSVD_HI:tsi_pkg::RSVD_LO] = tsi_pkg::RSVD_ONES;
		for (int i = 0; i < tsi_pkg::NUM_CH; i++)
		begin
			if (ch_hit[i])
			begin
				rd_byte[tsi_pkg::FLAG_W-1:0] = reg_sel_gate ? ch_gates[i] : ch_flags[i];
			end
		end
	end

	// ----------------------------------------
	// Wide (16-bit) read path
	// ----------------------------------------
	assign wide_valid = (wide_sel_ch < tsi_pkg::CH_SEL_W'(tsi_pkg::NUM_CH));

	// Pick the word, then mask lanes that were not requested
	always_comb
	begin
		wide_word = tsi_pkg::CNT_ZERO;
		for (int i = 0; i < tsi_pkg::NUM_CH; i++)
		begin
			if (wide_sel_ch == tsi_pkg::CH_SEL_W'(i))
			begin
				unique case (wide_sel_reg)
					tsi_pkg::TSI_WIDE_CNT: wide_word = channel_counter[i];
					tsi_pkg::TSI_WIDE_GRA: wide_word = general_reg_a[i];
					tsi_pkg::TSI_WIDE_GRB: wide_word = general_reg_b[i];
					tsi_pkg::TSI_WIDE_BRA: wide_word = buffer_reg_a[i];
					tsi_pkg::TSI_WIDE_BRB: wide_word = buffer_reg_b[i];
					default: wide_word = tsi_pkg::CNT_ZERO;
				endcase
			end
		end
		if (!wide_lane[tsi_pkg::LANE_HI])
		begin
			wide_word[tsi_pkg::CNT_W-1:tsi_pkg::REG_W] = '0;
		end
		if (!wide_lane[tsi_pkg::LANE_LO])
		begin
			wide_word[tsi_pkg::REG_W-1:0] = '0;
		end
	end

	// ----------------------------------------
	// Bus-side next state
	// ----------------------------------------
	// Answers one cycle after each strobe; read data holds until the next read
	always_comb
	begin
		nxt_state = state_ff;
		nxt_state.ack = reg_rd | reg_wr;
		nxt_state.err = (reg_rd | reg_wr) & ~sel_valid;
		if (reg_rd)
		begin
			nxt_state.rdata = rd_byte;
		end
		nxt_state.wide_ack = wide_rd;
		if (wide_rd)
		begin
			nxt_state.wide = wide_valid ? wide_word : tsi_pkg::CNT_ZERO;
		end
	end

	// Bus-side state register
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			state_ff <= TOP_RST;
		end
		else
		begin
			state_ff <= nxt_state;
		end
	end

	// Outputs
	assign reg_rdata = state_ff.rdata;
	assign reg_ack = state_ff.ack;
	assign reg_err = state_ff.err;
	assign wide_rdata = state_ff.wide;
	assign wide_ack = state_ff.wide_ack;

endmodule // tsi_timer_status_irq

// File: verification/tb.sv
// Self-checking bench for the timer status and interrupt gate top.
// Assumes default BIT7_READ, so idle registers read 8'hF8.
`timescale 1ns/1ps
module tb;
	logic clk_sys, rst, standby, reg_sel_gate, reg_rd, reg_wr, wide_rd, reg_ack, reg_err, wide_ack;
	logic phase_count_select, combo_mode_hi, combo_mode_lo, dma_on, dma_slow, ed;
	logic [2:0] reg_sel_ch, wide_sel_ch;
	logic [7:0] reg_wdata, reg_rdata;
	logic [1:0] wide_lane;
	logic [15:0] wide_rdata;
	logic [3:0] dma_ack_a;
	logic [31:0] seed, r;
	tsi_pkg::tsi_wide_sel_type wide_sel_reg;
	logic [4:0] cnt_tick, cnt_down, gra_capture_mode, grb_capture_mode, capture_a, capture_b;
	logic [4:0] wrap_irq, match_a_irq, match_b_irq;
	logic [4:0][15:0] channel_counter, general_reg_a, general_reg_b, buffer_reg_a, buffer_reg_b;
	int m_flag[5], m_gate[5], m_arm[5];
	int mismatches, compares;

	tsi_timer_status_irq tsi_timer_status_irq_inst (.clk_sys(clk_sys), .rst(rst),
		.standby(standby), .reg_sel_ch(reg_sel_ch), .reg_sel_gate(reg_sel_gate),
		.reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_ack(reg_ack), .reg_err(reg_err), .wide_rd(wide_rd), .wide_sel_ch(wide_sel_ch),
		.wide_sel_reg(wide_sel_reg), .wide_lane(wide_lane), .wide_rdata(wide_rdata),
		.wide_ack(wide_ack), .cnt_tick(cnt_tick), .cnt_down(cnt_down),
		.phase_count_select(phase_count_select), .combo_mode_hi(combo_mode_hi),
		.combo_mode_lo(combo_mode_lo), .channel_counter(channel_counter),
		.general_reg_a(general_reg_a), .general_reg_b(general_reg_b),
		.buffer_reg_a(buffer_reg_a), .buffer_reg_b(buffer_reg_b),
		.gra_capture_mode(gra_capture_mode), .grb_capture_mode(grb_capture_mode),
		.capture_a(capture_a), .capture_b(capture_b), .dma_ack_a(dma_ack_a),
		.wrap_irq(wrap_irq), .match_a_irq(match_a_irq), .match_b_irq(match_b_irq));
	tsi_dma_model tsi_dma_model_inst (.clk_sys(clk_sys), .rst(rst), .dma_on(dma_on),
		.dma_slow(dma_slow), .req(match_a_irq[3:0]), .dma_ack_a(dma_ack_a));

	// Clock, 20 ns period
	initial
	begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (exp !== got)
		begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic summarize();
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ----------------------------------------
	// Reference model of flags, gates and arming
	// ----------------------------------------
	always @(posedge clk_sys or posedge rst)
		for (int c = 0; c < 5; c++)
			if (rst || standby)
			begin
				m_flag[c] = 0;
				m_gate[c] = 0;
				m_arm[c] = 0;
			end
			else
			begin
				if (reg_rd && !reg_sel_gate && reg_sel_ch == c)
					m_arm[c] |= m_flag[c];
				if (reg_wr && reg_sel_ch == c && reg_sel_gate)
					m_gate[c] = reg_wdata[2:0];
				if (reg_wr && reg_sel_ch == c && !reg_sel_gate)
				begin
					m_flag[c] &= ~(m_arm[c] & ~reg_wdata[2:0]);
					m_arm[c] = 0;
				end
				if (c < 4 && dma_ack_a[c % 4])
					m_flag[c] &= 6;
				ed = cnt_down[c] && (c == 2 ? phase_count_select : c > 2 && combo_mode_hi && !combo_mode_lo);
				if (cnt_tick[c] && channel_counter[c] == (ed ? 16'h0000 : 16'hFFFF))
					m_flag[c] |= 4;
				if (gra_capture_mode[c] ? capture_a[c] : cnt_tick[c] && channel_counter[c] == general_reg_a[c])
					m_flag[c] |= 1;
				if (grb_capture_mode[c] ? capture_b[c] : cnt_tick[c] && channel_counter[c] == general_reg_b[c])
					m_flag[c] |= 2;
			end

	// Requests compared every cycle once settled
	always @(negedge clk_sys)
		if (!rst)
			for (int c = 0; c < 5; c++)
				chk("irq", 16'(m_flag[c] & m_gate[c]), {13'h0, wrap_irq[c], match_b_irq[c], match_a_irq[c]});

	// ----------------------------------------
	// Bus and event tasks
	// ----------------------------------------
	task automatic wr(input logic [2:0] ch, input logic g, input logic [7:0] d);
		{reg_sel_ch, reg_sel_gate, reg_wdata, reg_wr} = {ch, g, d, 1'b1};
		@(posedge clk_sys);
		#1 reg_wr = 1'b0;
		chk("wr_ack", {14'h0, ch > 3'h4, 1'b1}, {14'h0, reg_err, reg_ack});
	endtask

	task automatic rd(input logic [2:0] ch, input logic g);
		logic [7:0] e;
		{reg_sel_ch, reg_sel_gate, reg_rd} = {ch, g, 1'b1};
		e = {5'h1F, 3'(ch > 3'h4 ? 0 : g ? m_gate[ch] : m_flag[ch])};
		@(posedge clk_sys);
		#1 reg_rd = 1'b0;
		chk("rdata", {7'h0, 1'b1, e}, {7'h0, reg_ack, reg_rdata});
	endtask

	task automatic wide(input logic [2:0] ch, input int s, input logic [1:0] ln);
		logic [15:0] e;
		{wide_sel_ch, wide_lane, wide_rd} = {ch, ln, 1'b1};
		wide_sel_reg = tsi_pkg::tsi_wide_sel_type'(s);
		e = ch > 3'h4 ? 16'h0000 : s == 0 ? channel_counter[ch] : s == 1 ? general_reg_a[ch]
			: s == 2 ? general_reg_b[ch] : s == 3 ? buffer_reg_a[ch] : buffer_reg_b[ch];
		e &= {{8{ln[1]}}, {8{ln[0]}}};
		@(posedge clk_sys);
		#1 wide_rd = 1'b0;
		chk("wide", e, wide_ack ? wide_rdata : 16'hDEAD);
	endtask

	task automatic ev(input logic quiet);
		r = rnd();
		{cnt_tick, cnt_down} = {r[4:0] & r[9:5] & {5{!quiet}}, r[14:10]};
		capture_a = r[19:15] & r[24:20] & {5{!quiet}};
		capture_b = r[29:25] & r[24:20] & {5{!quiet}};
		standby = !quiet && r[31:26] == 6'h00;
		r = rnd();
		{gra_capture_mode, grb_capture_mode} = r[9:0];
		{phase_count_select, combo_mode_hi, combo_mode_lo} = r[12:10];
		for (int c = 0; c < 5; c++)
		begin
			r = rnd();
			channel_counter[c] = r[1:0] == 0 ? 16'hFFFF : r[1:0] == 1 ? 16'h0000 : {12'h000, r[5:2]};
			general_reg_a[c] = {12'h000, r[9:6]};
			general_reg_b[c] = {12'h000, r[13:10]};
			buffer_reg_a[c] = r[31:16];
			buffer_reg_b[c] = ~r[31:16];
		end
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		seed = 32'h0000_0030;
		{mismatches, compares} = 0;
		{rst, reg_rd, reg_wr, wide_rd, dma_on, dma_slow} = 6'h20;
		{reg_sel_ch, reg_sel_gate, reg_wdata, wide_sel_ch, wide_lane} = '0;
		wide_sel_reg = tsi_pkg::TSI_WIDE_CNT;
		ev(1'b1);
		repeat (16) @(posedge clk_sys);
		#1 rst = 1'b0;
		for (int c = 0; c < 8; c++)
		begin
			rd(3'(c), 1'b0);
			rd(3'(c), 1'b1);
		end
		// Wrap on channel 0 in the same cycle as an unarmed clear, then ones write, armed clear
		wr(3'h0, 1'b1, 8'hFF);
		channel_counter[0] = 16'hFFFF;
		cnt_tick = 5'h01;
		wr(3'h0, 1'b0, 8'h00);
		cnt_tick = 5'h00;
		rd(3'h0, 1'b0);
		wr(3'h0, 1'b0, 8'hFF);
		rd(3'h0, 1'b0);
		wr(3'h0, 1'b0, 8'hF8);
		// Random traffic, without DMA, with prompt DMA, with slow DMA
		for (int k = 0; k < 3; k++)
		begin
			{dma_on, dma_slow} = {k > 0, k == 2};
			repeat (1500)
			begin
				ev(1'b0);
				r = rnd();
				case (r[2:0])
					0, 1: rd(r[5:3], r[6]);
					2: wr(r[5:3], r[6], r[7] ? r[15:8] : {r[15:11], 3'h0});
					3: wide(r[5:3], int'(r[8:6]) % 5, r[10:9]);
					default:
					begin
						@(posedge clk_sys);
						#1;
					end
				endcase
			end
		end
		summarize();
	end
endmodule // tb

bind tsi_timer_status_irq tsi_asserts tsi_asserts_inst (.clk_sys(clk_sys), .rst(rst),
	.standby(standby), .reg_sel_ch(reg_sel_ch), .reg_sel_gate(reg_sel_gate), .reg_rd(reg_rd),
	.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
	.reg_err(reg_err), .wide_rd(wide_rd), .wide_lane(wide_lane), .wide_rdata(wide_rdata),
	.wide_ack(wide_ack), .cnt_tick(cnt_tick), .cnt_down(cnt_down),
	.channel_counter(channel_counter), .capture_a(capture_a), .dma_ack_a(dma_ack_a),
	.wrap_irq(wrap_irq), .match_a_irq(match_a_irq), .match_b_irq(match_b_irq));

// File: verification/tsi_asserts.sv
// Concurrent checks on the ports of the timer status and interrupt gate top.
// Assumes one clk_sys domain and an asynchronous active-high rst.
`timescale 1ns/1ps
module tsi_asserts (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic standby,
	input wire logic [2:0] reg_sel_ch,
	input wire logic reg_sel_gate,
	input wire logic reg_rd,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_ack,
	input wire logic reg_err,
	input wire logic wide_rd,
	input wire logic [1:0] wide_lane,
	input wire logic [15:0] wide_rdata,
	input wire logic wide_ack,
	input wire logic [4:0] cnt_tick,
	input wire logic [4:0] cnt_down,
	input wire logic [4:0][15:0] channel_counter,
	input wire logic [4:0] capture_a,
	input wire logic [3:0] dma_ack_a,
	input wire logic [4:0] wrap_irq,
	input wire logic [4:0] match_a_irq,
	input wire logic [4:0] match_b_irq
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	// Byte access answered next cycle, error only for a bad channel
	property p_ack;
		(reg_rd || reg_wr) |=> reg_ack && (reg_err == ($past(reg_sel_ch) > 3'h4));
	endproperty
	a_ack: assert property (p_ack) else $error("byte answer wrong");

	// Reserved bits read as ones
	property p_rsvd;
		reg_ack && $past(reg_rd) |-> reg_rdata[6:3] == 4'hF;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits wrong");

	// Unrequested upper lane reads zero
	property p_wide;
		wide_rd && !wide_lane[1] |=> wide_ack && wide_rdata[15:8] == 8'h00;
	endproperty
	a_wide: assert property (p_wide) else $error("wide read wrong");

	// Standby leaves every request low
	property p_standby;
		standby |=> !(|wrap_irq) && !(|match_a_irq) && !(|match_b_irq);
	endproperty
	a_standby: assert property (p_standby) else $error("irq in standby");

	// Without a bus write or standby a match B request holds
	property p_b_hold;
		match_b_irq[1] && !reg_wr && !standby |=> match_b_irq[1];
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("match b irq dropped");

	// A DMA start with no new event drops the match A request
	property p_dma_clr;
		dma_ack_a[0] && match_a_irq[0] && !cnt_tick[0] && !capture_a[0] && !reg_wr |=> !match_a_irq[0];
	endproperty
	a_dma_clr: assert property (p_dma_clr) else $error("dma clear missed");

	// Writing ones to the flags keeps them
	property p_one_write;
		reg_wr && !reg_sel_gate && reg_sel_ch == 3'h0 && reg_wdata[2:0] == 3'h7 && match_a_irq[0]
			&& !dma_ack_a[0] && !standby |=> match_a_irq[0];
	endproperty
	a_one_write: assert property (p_one_write) else $error("flag cleared by one");

	// Channel 0 cannot count down, so a tick at zero is no wrap
	property p_no_down;
		cnt_tick[0] && cnt_down[0] && channel_counter[0] == 16'h0000 && !wrap_irq[0] && !reg_wr
			|=> !wrap_irq[0];
	endproperty
	a_no_down: assert property (p_no_down) else $error("false underflow");

	// A wrap request rises only after a tick or a bus write
	property p_wrap_cause;
		$rose(wrap_irq[0]) |-> $past(cnt_tick[0]) || $past(reg_wr);
	endproperty
	a_wrap_cause: assert property (p_wrap_cause) else $error("wrap irq without cause");
endmodule // tsi_asserts

// File: verification/tsi_dma_model.sv
// DMA controller model answering match A requests of channels 0 to 3.
// Assumes requests are levels on clk_sys; one transfer start pulse per request.
`timescale 1ns/1ps
module tsi_dma_model (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic dma_on,
	input wire logic dma_slow,
	input wire logic [3:0] req,
	output logic [3:0] dma_ack_a
);
	int wait_cnt[4];

	// Start a transfer once the request has stood for the chosen latency
	always @(posedge clk_sys or posedge rst)
		for (int c = 0; c < 4; c++)
			if (rst || !dma_on || !req[c] || dma_ack_a[c])
			begin
				wait_cnt[c] <= 0;
				dma_ack_a[c] <= 1'b0;
			end
			else
			begin
				wait_cnt[c] <= wait_cnt[c] + 1;
				dma_ack_a[c] <= wait_cnt[c] >= (dma_slow ? 3 : 0);
			end
endmodule // tsi_dma_model
